// *** include/pllcc_pkg.sv ***
package pllcc_pkg;

   // reference-domain timing
   localparam int START_DELAY_REF = 16384;
   localparam int CAL_REF_CYCLES  = 550;
   localparam int REF_DIV         = 2;
   localparam int CAL_TICKS       = CAL_REF_CYCLES / REF_DIV;

   // system clock, 40 MHz
   localparam int CLK_PERIOD_PS   = 25000;
   localparam int RST_MIN_NS      = 100;
   localparam int RST_MIN_CYC     = (RST_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int CAL_TIME_NS     = 20000;
   localparam int CAL_SLOW_CYC    = (CAL_TIME_NS * 1000) / CLK_PERIOD_PS;
   localparam int REF_MISS_CYC    = 8;

   // loop ratio select codes
   localparam logic [1:0] LR_P3_F24 = 2'h0;
   localparam logic [1:0] LR_P5_F15 = 2'h1;
   localparam logic [1:0] LR_P3_F25 = 2'h2;
   localparam logic [1:0] LR_P4_F20 = 2'h3;

   localparam logic [2:0] PRE_3     = 3'h3;
   localparam logic [2:0] PRE_4     = 3'h4;
   localparam logic [2:0] PRE_5     = 3'h5;
   localparam logic [4:0] FB_15     = 5'h0F;
   localparam logic [4:0] FB_20     = 5'h14;
   localparam logic [4:0] FB_24     = 5'h18;
   localparam logic [4:0] FB_25     = 5'h19;

   // post divider select codes
   localparam logic [2:0] PD_DIV1   = 3'h0;
   localparam logic [2:0] PD_DIV2   = 3'h1;
   localparam logic [2:0] PD_DIV3   = 3'h2;
   localparam logic [2:0] PD_DIV4   = 3'h3;
   localparam logic [2:0] PD_RSV4   = 3'h4;
   localparam logic [2:0] PD_DIV6   = 3'h5;
   localparam logic [2:0] PD_RSV6   = 3'h6;
   localparam logic [2:0] PD_DIV8   = 3'h7;

   // driver kind select codes
   localparam logic [1:0] DK_SINGLE = 2'h0;
   localparam logic [1:0] DK_LVDS   = 2'h1;
   localparam logic [1:0] DK_ECL    = 2'h2;
   localparam logic [1:0] DK_ECL_MON = 2'h3;

   typedef enum logic [1:0] {DRV_SINGLE, DRV_LVDS, DRV_ECL} pllcc_drv_t;

   typedef struct packed {
      logic [2:0] prescale;
      logic [4:0] feedback;
      logic [3:0] post_div;
      logic       post_div_ok;
      pllcc_drv_t drive;
      logic       xtal_mon;
   } pllcc_cfg_t;

   localparam pllcc_cfg_t CFG_RESET = '{PRE_3, FB_24, 4'h1, 1'b1, DRV_SINGLE, 1'b0};

   // reserved post divider codes cannot lock
   function automatic logic pllcc_post_ok(input logic [2:0] pd);
      pllcc_post_ok = (pd != PD_RSV4) && (pd != PD_RSV6);
   endfunction

   // pins to divider pair, post ratio and driver kind
   function automatic pllcc_cfg_t pllcc_decode(input logic [1:0] lr,
                                               input logic [2:0] pd,
                                               input logic [1:0] dk);
      pllcc_cfg_t c;
      c = CFG_RESET;
      case (lr)
         LR_P3_F24: begin c.prescale = PRE_3; c.feedback = FB_24; end
         LR_P5_F15: begin c.prescale = PRE_5; c.feedback = FB_15; end
         LR_P3_F25: begin c.prescale = PRE_3; c.feedback = FB_25; end
         default:   begin c.prescale = PRE_4; c.feedback = FB_20; end
      endcase
      case (pd)
         PD_DIV1: c.post_div = 4'h1;
         PD_DIV2: c.post_div = 4'h2;
         PD_DIV3: c.post_div = 4'h3;
         PD_DIV4: c.post_div = 4'h4;
         PD_DIV6: c.post_div = 4'h6;
         PD_DIV8: c.post_div = 4'h8;
         default: c.post_div = 4'h0;
      endcase
      c.post_div_ok = pllcc_post_ok(pd);
      case (dk)
         DK_SINGLE: c.drive = DRV_SINGLE;
         DK_LVDS:   c.drive = DRV_LVDS;
         default:   c.drive = DRV_ECL;
      endcase
      c.xtal_mon = (dk == DK_ECL_MON);
      return c;
   endfunction

endpackage

// *** verification/pllcc_board_model.sv ***
`timescale 1ns/1ps
// board side: reference oscillator and restart pulse driver
module pllcc_board_model #(
   parameter int HALF = 3
)(
   input  wire logic       clk_sys_in,
   input  wire logic       ref_run_in,
   input  wire logic       pulse_go_in,
   input  wire logic [3:0] pulse_len_in,
   output logic            reference_out,
   output logic            device_restart_n_out
);
   logic [3:0] half_q = 4'h0;
   logic [3:0] pulse_q = 4'h0;

   initial reference_out = 1'b0;
   initial device_restart_n_out = 1'b1;

   // reference runs from time zero, stops dead when told to
   always @(posedge clk_sys_in)
   begin
      if (ref_run_in)
      begin
         half_q <= (half_q == HALF - 1) ? 4'h0 : half_q + 4'h1;
         if (half_q == HALF - 1)
            reference_out <= !reference_out;
      end
   end

   // restart held low for exactly the requested cycles
   always @(posedge clk_sys_in)
   begin
      if (pulse_q != 4'h0)
      begin
         pulse_q <= pulse_q - 4'h1;
         device_restart_n_out <= (pulse_q == 4'h1);
      end
      else if (pulse_go_in)
      begin
         pulse_q <= pulse_len_in;
         device_restart_n_out <= 1'b0;
      end
   end
endmodule

// *** verification/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
   import pllcc_pkg::*;
   localparam int SD = 16;
   localparam int CL = 4;
   localparam int P  = 6;
   localparam int DLO = (SD - 1) * P - 4;
   localparam int DHI = (SD + 1) * P + 4;

   logic       clk_sys_in = 1'b0;
   logic       reset_in   = 1'b1;
   logic       ref_run    = 1'b1;
   logic       pulse_go   = 1'b0;
   logic [3:0] pulse_len  = 4'h0;
   logic       ce         = 1'b1;
   logic [1:0] lr         = 2'h3;
   logic [2:0] pd         = 3'h0;
   logic [1:0] dk         = 2'h3;
   logic       ref_w;
   logic       rst_n_w;
   pllcc_cfg_t cfg_out;
   logic       out_buf_en_out;
   logic       crystal_monitor_out;
   logic       cal_busy_out;
   logic       cal_done_out;
   logic       power_down_out;
   logic       cal_slow_out;
   int         fail_count = 0;
   int         n_tests = 0;
   int         t0;
   int         t1;
   pllcc_cfg_t ex;
   // expected tables, indexed by pin code
   logic [2:0] pre_t [4] = '{3'h3, 3'h5, 3'h3, 3'h4};
   logic [4:0] fb_t  [4] = '{5'h18, 5'h0F, 5'h19, 5'h14};
   logic [3:0] pdv_t [8] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h0, 4'h6, 4'h0, 4'h8};

   // 40 MHz system clock
   initial
   begin
      forever #12.5 clk_sys_in = !clk_sys_in;
   end

   pllcc_board_model #(.HALF(P / 2)) i_pllcc_board_model (
      .clk_sys_in           (clk_sys_in),
      .ref_run_in           (ref_run),
      .pulse_go_in          (pulse_go),
      .pulse_len_in         (pulse_len),
      .reference_out        (ref_w),
      .device_restart_n_out (rst_n_w)
   );

   pllcc_seq #(.START_DELAY(SD), .CAL_LEN(CL), .SLOW_CYC(20)) i_pllcc_seq (
      .clk_sys_in            (clk_sys_in),
      .reset_in              (reset_in),
      .reference_in          (ref_w),
      .device_restart_n_in   (rst_n_w),
      .chip_enable_in        (ce),
      .loop_ratio_sel_hi_in  (lr[1]),
      .loop_ratio_sel_lo_in  (lr[0]),
      .post_div_sel_2_in     (pd[2]),
      .post_div_sel_1_in     (pd[1]),
      .post_div_sel_0_in     (pd[0]),
      .driver_kind_sel_hi_in (dk[1]),
      .driver_kind_sel_lo_in (dk[0]),
      .cfg_out               (cfg_out),
      .out_buf_en_out        (out_buf_en_out),
      .crystal_monitor_out   (crystal_monitor_out),
      .cal_busy_out          (cal_busy_out),
      .cal_done_out          (cal_done_out),
      .power_down_out        (power_down_out),
      .cal_slow_out          (cal_slow_out)
   );

   task automatic report_and_stop();
      if (fail_count == 0 && n_tests > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic chk_b(input logic got, input logic exp);
      n_tests++;
      if (got !== exp)
      begin
         fail_count++;
         $display("[ERR] %0t flag %b expected %b", $time, got, exp);
      end
   endtask

   task automatic chk_cfg(input pllcc_cfg_t got, input pllcc_cfg_t exp);
      n_tests++;
      if (got !== exp)
      begin
         fail_count++;
         $display("[ERR] %0t cfg %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_rng(input int v, input int lo, input int hi);
      n_tests++;
      if (v < lo || v > hi)
      begin
         fail_count++;
         $display("[ERR] %0t count %0d outside %0d..%0d", $time, v, lo, hi);
      end
   endtask

   task automatic cycles(input int n);
      repeat (n) @(negedge clk_sys_in);
   endtask

   // time to busy, then busy length; buffers must stay off meanwhile
   task automatic wait_cal(input int lim, output int tb, output int tl);
      tb = 0;
      tl = 0;
      while (cal_busy_out !== 1'b1 && tb < lim)
      begin
         @(negedge clk_sys_in);
         tb++;
      end
      // a fresh calibration starts with the slow flag clear
      if (cal_busy_out === 1'b1)
         chk_b(cal_slow_out, 1'b0);
      while (cal_busy_out === 1'b1 && tl < 400)
      begin
         chk_b(out_buf_en_out, 1'b0);
         @(negedge clk_sys_in);
         tl++;
      end
   endtask

   task automatic pulse(input logic [3:0] len);
      @(posedge clk_sys_in);
      pulse_go <= 1'b1;
      pulse_len <= len;
      @(posedge clk_sys_in);
      pulse_go <= 1'b0;
      repeat (len + 1) @(posedge clk_sys_in);
      // outputs launched on the last edge have settled by the falling edge
      @(negedge clk_sys_in);
   endtask

   // hang guard, generous against the thousand or so cycles needed
   initial
   begin
      repeat (20000) @(posedge clk_sys_in);
      fail_count++;
      report_and_stop();
   end

   initial
   begin
      cycles(12);
      chk_cfg(cfg_out, CFG_RESET);
      chk_b(power_down_out, 1'b1);
      chk_b(out_buf_en_out, 1'b0);
      @(posedge clk_sys_in);
      reset_in <= 1'b0;
      // power-on calibration timing
      wait_cal(400, t0, t1);
      chk_rng(t0, DLO, DHI);
      chk_rng(t1, (2 * CL - 2) * P, (2 * CL + 1) * P);
      chk_b(cal_done_out, 1'b1);
      chk_b(out_buf_en_out, 1'b1);
      chk_b(cal_slow_out, 1'b1);
      // every pin code of the three selects
      for (int i = 0; i < 8; i++)
      begin
         @(posedge clk_sys_in);
         lr <= i[1:0];
         pd <= i[2:0];
         dk <= i[1:0];
         cycles(3);
         ex = '{pre_t[i % 4], fb_t[i % 4], pdv_t[i], !(i == 4 || i == 6),
                (i % 4 == 0) ? DRV_SINGLE : ((i % 4 == 1) ? DRV_LVDS : DRV_ECL),
                (i % 4 == 3)};
         chk_cfg(cfg_out, ex);
         chk_b(crystal_monitor_out, i % 4 == 3);
      end
      // chip power low gates buffers, no recalibration
      @(posedge clk_sys_in);
      ce <= 1'b0;
      cycles(3);
      chk_b(power_down_out, 1'b1);
      chk_b(out_buf_en_out, 1'b0);
      chk_b(crystal_monitor_out, 1'b0);
      @(posedge clk_sys_in);
      ce <= 1'b1;
      pd <= 3'h0;
      cycles(3);
      chk_b(power_down_out, 1'b0);
      chk_b(out_buf_en_out, 1'b1);
      chk_b(cal_done_out, 1'b1);
      // too short a pulse is ignored, minimum width restarts
      pulse(4'h3);
      cycles(3);
      chk_b(cal_done_out, 1'b1);
      pulse(4'h4);
      chk_b(cal_done_out, 1'b0);
      chk_b(out_buf_en_out, 1'b0);
      wait_cal(400, t0, t1);
      chk_rng(t0, DLO, DHI);
      chk_b(out_buf_en_out, 1'b1);
      // reserved post divider holds the start
      @(posedge clk_sys_in);
      pd <= 3'h6;
      pulse(4'h4);
      wait_cal(200, t0, t1);
      chk_rng(t0, 200, 200);
      chk_b(out_buf_en_out, 1'b0);
      @(posedge clk_sys_in);
      pd <= 3'h7;
      wait_cal(400, t0, t1);
      chk_rng(t0, 0, 4);
      // absent reference holds the start
      @(posedge clk_sys_in);
      ref_run <= 1'b0;
      pulse(4'h4);
      wait_cal(200, t0, t1);
      chk_rng(t0, 200, 200);
      @(posedge clk_sys_in);
      ref_run <= 1'b1;
      wait_cal(400, t0, t1);
      chk_rng(t0, DLO - 8, DHI + 8);
      chk_b(cal_done_out, 1'b1);
      report_and_stop();
   end
endmodule

// *** verilog/pllcc_ref_div.sv ***
`timescale 1ns/1ps
module pllcc_ref_div
   import pllcc_pkg::*;
#(
   parameter int DIV      = REF_DIV,
   parameter int MISS_CYC = REF_MISS_CYC
)(
   input  wire logic clk_sys_in,
   input  wire logic reset_in,
   input  wire logic reference_in,
   output logic      ref_edge_out,
   output logic      div_tick_out,
   output logic      ref_present_out
);
   localparam int DW = (DIV > 1) ? $clog2(DIV) : 1;
   localparam int MW = $clog2(MISS_CYC + 1);

   if (DIV < 1 || MISS_CYC < 2)
      $error("pllcc_ref_div: unsupported DIV or MISS_CYC");

   logic          ref_last_q, ref_last_d;
   logic          edge_q, edge_d;
   logic          tick_q, tick_d;
   logic          pres_q, pres_d;
   logic [DW-1:0] div_q, div_d;
   logic [MW-1:0] miss_q, miss_d;
   logic          rise;

   // edge detect, divide-down and presence watchdog
   always_comb
   begin
      rise       = reference_in & ~ref_last_q;
      ref_last_d = reference_in;
      edge_d     = rise;
      tick_d     = 1'b0;
      div_d      = div_q;
      if (rise)
      begin
         if (div_q == DW'(DIV - 1))
         begin
            div_d  = '0;
            tick_d = 1'b1;
         end
         else
            div_d = div_q + 1'b1;
      end
      miss_d = rise ? '0 : ((miss_q == MW'(MISS_CYC)) ? miss_q : miss_q + 1'b1);
      pres_d = (miss_d != MW'(MISS_CYC));
   end

   always_ff @(posedge clk_sys_in)
   begin
      if (reset_in)
      begin
         ref_last_q <= 1'b1; // a reference already high at release is no edge
         edge_q     <= 1'b0;
         tick_q     <= 1'b0;
         pres_q     <= 1'b0;
         div_q      <= '0;
         miss_q     <= MW'(MISS_CYC);
      end
      else
      begin
         ref_last_q <= ref_last_d;
         edge_q     <= edge_d;
         tick_q     <= tick_d;
         pres_q     <= pres_d;
         div_q      <= div_d;
         miss_q     <= miss_d;
      end
   end

   assign ref_edge_out    = edge_q;
   assign div_tick_out    = tick_q;
   assign ref_present_out = pres_q;

   // a tick only comes with a reference edge
   a_tick_on_edge: assert property (@(posedge clk_sys_in) disable iff (reset_in)
      div_tick_out |-> ref_edge_out)
      else $error("divided tick without reference edge");
endmodule

// *** verilog/pllcc_seq.sv ***
`timescale 1ns/1ps
// Contract
// - wait 16384 reference cycles before calibrating
// - calibration lasts about twenty microseconds
// - restart pulse re-runs calibration any time
// - buffers off during calibration, on after
// - calibration timed from divided reference clock
// - calibrate only with reference and lockable setting
// - prescaler and feedback chosen as pair
// - output divider from its own pins
// - driver kind from output type pins
// - chip power low disables output buffers
// - loop ratio code to divider pair mapping
// - post divider code mapping, two reserved
// - driver kind mapping, code 3 enables monitor
// - power low: outputs off; high: active
module pllcc_seq
   import pllcc_pkg::*;
#(
   parameter int START_DELAY = START_DELAY_REF,
   parameter int CAL_LEN     = CAL_TICKS,
   parameter int SLOW_CYC    = CAL_SLOW_CYC
)(
   input  wire logic        clk_sys_in,
   input  wire logic        reset_in,
   input  wire logic        reference_in,
   input  wire logic        device_restart_n_in,
   input  wire logic        chip_enable_in,
   input  wire logic        loop_ratio_sel_hi_in,
   input  wire logic        loop_ratio_sel_lo_in,
   input  wire logic        post_div_sel_2_in,
   input  wire logic        post_div_sel_1_in,
   input  wire logic        post_div_sel_0_in,
   input  wire logic        driver_kind_sel_hi_in,
   input  wire logic        driver_kind_sel_lo_in,
   output pllcc_cfg_t       cfg_out,
   output logic             out_buf_en_out,
   output logic             crystal_monitor_out,
   output logic             cal_busy_out,
   output logic             cal_done_out,
   output logic             power_down_out,
   output logic             cal_slow_out
);
   localparam int SDW = $clog2(START_DELAY + 1); // room for the full edge count
   localparam int CLW = $clog2(CAL_LEN);
   localparam int SLW = $clog2(SLOW_CYC + 1);
   localparam int RLW = $clog2(RST_MIN_CYC + 1);

   if (START_DELAY < 2 || CAL_LEN < 2 || SLOW_CYC < 2)
      $error("pllcc_seq: counts must be at least 2");

   typedef enum logic [1:0] {ST_HOLD, ST_DELAY, ST_CAL, ST_DONE} pllcc_state_t;

   logic         ref_edge;
   logic         cal_tick;
   logic         ref_ok;

   // reference edge, divided tick and presence, all in the system domain
   pllcc_ref_div u_ref_div (
      .clk_sys_in      (clk_sys_in),
      .reset_in        (reset_in),
      .reference_in    (reference_in),
      .ref_edge_out    (ref_edge),
      .div_tick_out    (cal_tick),
      .ref_present_out (ref_ok)
   );

   // ---------------- pin decode ----------------
   pllcc_cfg_t   cfg_q, cfg_d;
   logic [1:0]   lr_sel;
   logic [2:0]   pd_sel;
   logic [1:0]   dk_sel;

   // static pins are re-decoded every cycle; straps may move after reset
   always_comb
   begin
      lr_sel = {loop_ratio_sel_hi_in, loop_ratio_sel_lo_in};
      pd_sel = {post_div_sel_2_in, post_div_sel_1_in, post_div_sel_0_in};
      dk_sel = {driver_kind_sel_hi_in, driver_kind_sel_lo_in};
      cfg_d  = pllcc_decode(lr_sel, pd_sel, dk_sel);
   end

   always_ff @(posedge clk_sys_in)
   begin
      if (reset_in)
         cfg_q <= CFG_RESET;
      else
         cfg_q <= cfg_d;
   end

   // ---------------- restart filter ----------------
   logic [RLW-1:0] low_cnt_q, low_cnt_d;
   logic           restart_req;

   // short glitches are ignored; only a held low restarts the sequence
   always_comb
   begin
      restart_req = (low_cnt_q == RLW'(RST_MIN_CYC));
      if (device_restart_n_in)
         low_cnt_d = '0;
      else if (restart_req)
         low_cnt_d = low_cnt_q;
      else
         low_cnt_d = low_cnt_q + 1'b1;
   end

   always_ff @(posedge clk_sys_in)
   begin
      if (reset_in)
         low_cnt_q <= '0;
      else
         low_cnt_q <= low_cnt_d;
   end

   // ---------------- calibration sequencer ----------------
   pllcc_state_t   state_q, state_d;
   logic [SDW-1:0] dly_cnt_q, dly_cnt_d;
   logic [CLW-1:0] cal_cnt_q, cal_cnt_d;
   logic [SLW-1:0] slow_cnt_q, slow_cnt_d;
   logic           slow_q, slow_d;
   logic           dly_end;
   logic           start_ok;

   // power-on release enters the delay directly; a restart parks in hold
   always_comb
   begin
      state_d    = state_q;
      dly_cnt_d  = dly_cnt_q;
      cal_cnt_d  = cal_cnt_q;
      slow_cnt_d = slow_cnt_q;
      slow_d     = slow_q;
      dly_end    = (dly_cnt_q == SDW'(START_DELAY)); // every delay edge seen
      start_ok   = ref_ok && cfg_q.post_div_ok;
      case (state_q)
         ST_HOLD:
         begin
            dly_cnt_d = '0;
            if (device_restart_n_in && !restart_req)
               state_d = ST_DELAY;
         end
         ST_DELAY:
         begin
            // the delay saturates, so a late lockable setting still starts cleanly
            if (ref_edge && !dly_end)
               dly_cnt_d = dly_cnt_q + 1'b1;
            if (dly_end && start_ok)
            begin
               state_d    = ST_CAL;
               cal_cnt_d  = '0;
               slow_cnt_d = '0;
               slow_d     = 1'b0;
            end
         end
         ST_CAL:
         begin
            if (cal_tick)
            begin
               if (cal_cnt_q == CLW'(CAL_LEN - 1))
                  state_d = ST_DONE;
               else
                  cal_cnt_d = cal_cnt_q + 1'b1;
            end
            // flags a reference too slow for the nominal interval
            if (slow_cnt_q == SLW'(SLOW_CYC))
               slow_d = 1'b1;
            else
               slow_cnt_d = slow_cnt_q + 1'b1;
         end
         ST_DONE:
         begin
            state_d = ST_DONE;
         end
         default:
         begin
            state_d = ST_HOLD;
         end
      endcase
      if (restart_req)
         state_d = ST_HOLD;
   end

   always_ff @(posedge clk_sys_in)
   begin
      if (reset_in)
      begin
         state_q    <= ST_DELAY;
         dly_cnt_q  <= '0;
         cal_cnt_q  <= '0;
         slow_cnt_q <= '0;
         slow_q     <= 1'b0;
      end
      else
      begin
         state_q    <= state_d;
         dly_cnt_q  <= dly_cnt_d;
         cal_cnt_q  <= cal_cnt_d;
         slow_cnt_q <= slow_cnt_d;
         slow_q     <= slow_d;
      end
   end

   // ---------------- output gating ----------------
   logic busy_q, busy_d;
   logic done_q, done_d;
   logic buf_en_q, buf_en_d;
   logic mon_q, mon_d;
   logic pd_q, pd_d;

   // buffers follow the next-state done decode, registered alongside the done flag
   always_comb
   begin
      busy_d   = (state_d == ST_CAL);
      done_d   = (state_d == ST_DONE);
      buf_en_d = done_d && chip_enable_in;
      mon_d    = cfg_d.xtal_mon && chip_enable_in;
      pd_d     = !chip_enable_in;
   end

   always_ff @(posedge clk_sys_in)
   begin
      if (reset_in)
      begin
         busy_q   <= 1'b0;
         done_q   <= 1'b0;
         buf_en_q <= 1'b0;
         mon_q    <= 1'b0;
         pd_q     <= 1'b1;
      end
      else
      begin
         busy_q   <= busy_d;
         done_q   <= done_d;
         buf_en_q <= buf_en_d;
         mon_q    <= mon_d;
         pd_q     <= pd_d;
      end
   end

   assign cfg_out             = cfg_q;
   assign out_buf_en_out      = buf_en_q;
   assign crystal_monitor_out = mon_q;
   assign cal_busy_out        = busy_q;
   assign cal_done_out        = done_q;
   assign power_down_out      = pd_q;
   assign cal_slow_out        = slow_q;

   // ---------------- checks ----------------
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (reset_in);

   a_buf_off_cal: assert property (cal_busy_out |-> !out_buf_en_out)
      else $error("buffers enabled during calibration");

   a_ce_low_off: assert property (!chip_enable_in |=> !out_buf_en_out && power_down_out)
      else $error("buffers enabled while powered down");

   // the buffer enable registers the previous cycle's chip enable, so compare against last enable
   a_buf_on_done: assert property (cal_done_out |-> out_buf_en_out == $past(chip_enable_in))
      else $error("buffers not enabled after calibration");

   a_start_delay: assert property (state_q == ST_DELAY && state_d == ST_CAL
      |-> dly_cnt_q == SDW'(START_DELAY))
      else $error("calibration began before start delay");

   a_cal_length: assert property (state_q == ST_CAL && state_d == ST_DONE
      |-> cal_cnt_q == CLW'(CAL_LEN - 1) && cal_tick)
      else $error("calibration interval wrong length");

   a_cal_needs_ref: assert property (state_q == ST_DELAY && state_d == ST_CAL
      |-> ref_ok && cfg_q.post_div_ok)
      else $error("calibration started without reference or valid setting");

   a_restart_held: assert property ((!device_restart_n_in)[*4] |=> ##1 state_q == ST_HOLD
      && !cal_done_out)
      else $error("held restart did not restart sequence");

   a_done_after_cal: assert property ($rose(cal_done_out) |-> $past(cal_busy_out))
      else $error("done without calibration");

   a_pair_map: assert property (lr_sel == LR_P5_F15 |=> cfg_out.prescale == PRE_5
      && cfg_out.feedback == FB_15)
      else $error("loop ratio pair wrong");

   a_post_rsv: assert property (pd_sel == PD_RSV4 || pd_sel == PD_RSV6
      |=> !cfg_out.post_div_ok)
      else $error("reserved post divider accepted");

   a_mon_code: assert property (chip_enable_in && dk_sel == DK_ECL_MON
      |=> crystal_monitor_out && cfg_out.drive == DRV_ECL)
      else $error("monitor output not enabled");

   c_cal_done: cover property ($rose(cal_done_out));
   c_restart_in_cal: cover property (cal_busy_out && restart_req);
   c_power_down: cover property (cal_done_out && $fell(chip_enable_in));
   c_slow_ref: cover property ($rose(cal_slow_out));
endmodule
